// ==== core/nibble_defs.vh ====
// Constants for the four-bit instruction execute core
`ifndef NIBBLE_DEFS_VH
`define NIBBLE_DEFS_VH

// ****************************************
// Timing
// ****************************************
`define PHASES_PER_CYCLE   3'h6
`define LAST_PHASE         3'h5

// ****************************************
// Opcode classes (upper bits of the instruction)
// ****************************************
`define OP_BRANCH          2'h2
`define OP_CALL            2'h3
`define OP_MISC_A          4'h0
`define OP_LOAD_PAGE       4'h1
`define OP_MISC_B          4'h2
`define OP_BITS            4'h3
`define OP_CONST_INDEX     4'h4
`define OP_LE_CONST        4'h5
`define OP_CONST_RAM       4'h6
`define OP_NE_CONST        4'h7
`define BITS_SET           2'h0
`define BITS_CLEAR         2'h1
`define BITS_TEST          2'h2
`define BITS_FILE          2'h3

// ****************************************
// Miscellaneous operations, code {op[5], op[3:0]}
// ****************************************
`define M_MOVE_ACC_INDEX   5'h00
`define M_MOVE_INDEX_ACC   5'h01
`define M_ZERO_ACC         5'h02
`define M_STORE_ACC        5'h03
`define M_STORE_BUMP       5'h04
`define M_STORE_ZERO       5'h05
`define M_LOAD_INDEX_RAM   5'h06
`define M_LOAD_ACC_RAM     5'h07
`define M_SWAP_RAM_ACC     5'h08
`define M_ADD_RAM_ACC      5'h09
`define M_SUB_ACC_RAM      5'h0A
`define M_INC_RAM_ACC      5'h0B
`define M_DEC_RAM_ACC      5'h0C
`define M_INC_ACC          5'h0D
`define M_INC_INDEX        5'h0E
`define M_DEC_ACC          5'h0F
`define M_DEC_INDEX        5'h10
`define M_ADD_SIX          5'h11
`define M_ADD_EIGHT        5'h12
`define M_ADD_TEN          5'h13
`define M_NEGATE_ACC       5'h14
`define M_LE_RAM           5'h15
`define M_RAM_NONZERO      5'h16
`define M_INDEX_NE_ACC     5'h17
`define M_KEYS_NONZERO     5'h18
`define M_KEYS_TO_ACC      5'h19
`define M_SET_STROBE       5'h1A
`define M_CLEAR_STROBE     5'h1B
`define M_OUTPUT_XFER      5'h1C
`define M_CLEAR_OUTPUT     5'h1D
`define M_INVERT_FILE      5'h1E
`define M_SUB_RETURN       5'h1F

// ****************************************
// Constants added by the constant-add operations
// ****************************************
`define K_SIX              4'h6
`define K_EIGHT            4'h8
`define K_TEN              4'hA

// ****************************************
// Register port
// ****************************************
`define REG_CTRL           4'h0
`define REG_STATE          4'h1
`define CTRL_RUN_BIT       0
`define CTRL_RESET         1'h1
`define STATUS_RESET       1'h1
`define NIBBLE_ZERO        4'h0
`define NIBBLE_ONE         4'h1
`define NIBBLE_ALL         4'hF

`endif

// ==== core/nibble_ram.v ====
// Four files of sixteen four-bit words addressed by file select and index
`timescale 1ns/10ps
module nibble_ram #(
  parameter FILES = 4,
  parameter WORDS = 16
) (
  input  wire       i_clk,
  input  wire       i_we,
  input  wire [1:0] i_file,
  input  wire [3:0] i_word,
  input  wire [3:0] i_wdata,
  output wire [3:0] o_rdata
);

  reg  [3:0] mem [0:FILES*WORDS-1];
  wire [5:0] addr;

  // Word address from the two file bits and the index
  assign addr    = {i_file, i_word};
  assign o_rdata = mem[addr];

  // Write port, contents are not cleared by reset
  always @(posedge i_clk) begin
    if (i_we) begin
      mem[addr] <= i_wdata;
    end
  end

endmodule

// ==== core/nibble_cpu_instruction_execute.v ====
// Instruction execute core of a four-bit one-chip microcomputer
//
// Behaviour
// - Six clock phases make one instruction cycle; each instruction finishes in one.
// - Status rests at one; a zero lasts one following cycle then returns.
// - Branch or call taken only with status one, else counter advances.
// - Carry instructions set status on carry out of bit three, else clear.
// - Not-equal compares set status when values differ; tests change no data, except index unlike accumulator loads latch.
// - Accumulator to index, index to accumulator, clear accumulator; status set to one.
// - Store accumulator to RAM; variants bump index or zero accumulator.
// - Load RAM into index or accumulator; swap RAM and accumulator.
// - Add RAM to accumulator on carry; subtract accumulator from RAM on no borrow.
// - RAM plus one or minus one into accumulator with carry or no borrow.
// - Plain accumulator increment; index increment carry; decrements set on no borrow.
// - Add six, eight or ten to accumulator, status on carry.
// - Negate accumulator; status one when the result is zero.
// - Status one when accumulator is at most RAM word or constant.
// - RAM nonzero or index unlike constant; index unlike accumulator also loads latch.
// - Set or clear a RAM bit; bit test gives status one on a one.
// - Constant into index, or constant into RAM then index bumped.
// - Keys nonzero test, or keys copied to accumulator.
// - Set or clear the strobe latch picked by the index only.
// - Output transfer loads accumulator and latch; another instruction clears it.
// - File select loaded from constant or inverted.
// - Branch or call on status, unconditional return, page buffer load.
// - Taken branch or call copies page buffer to page; call keeps return page.
// - One level of return address kept in a return register.
// - Two file bits pick one of four files, index picks word.
`timescale 1ns/10ps
`include "nibble_defs.vh"
module nibble_cpu_instruction_execute #(
  parameter STROBES = 13
) (
  input  wire               i_clk,
  input  wire               i_resetn,
  input  wire               i_ce,
  input  wire [7:0]         i_rom_data,
  input  wire [3:0]         i_keys,
  input  wire [3:0]         i_reg_addr,
  input  wire [31:0]        i_reg_wdata,
  input  wire               i_reg_wr,
  input  wire               i_reg_rd,
  output wire [9:0]         o_rom_addr,
  output reg  [STROBES-1:0] o_strobe,
  output reg  [4:0]         o_parallel,
  output reg                o_cycle_end,
  output reg  [31:0]        o_reg_rdata
);

  // ****************************************
  // Architectural state
  // ****************************************
  reg  [2:0] phase_reg;
  reg        run_reg;
  reg  [3:0] acc_reg;
  reg  [3:0] acc_next;
  reg  [3:0] index_reg;
  reg  [3:0] index_next;
  reg  [1:0] file_reg;
  reg  [1:0] file_next;
  reg        status_reg;
  reg        status_next;
  reg        latch_reg;
  reg        latch_next;
  reg  [5:0] pc_reg;
  reg  [5:0] pc_next;
  reg  [3:0] page_reg;
  reg  [3:0] page_next;
  reg  [3:0] pbuf_reg;
  reg  [3:0] pbuf_next;
  reg  [5:0] ret_reg;
  reg  [5:0] ret_next;
  reg        ram_we;
  reg  [3:0] ram_wdata;
  reg        strobe_we;
  reg        strobe_val;
  reg        out_load;
  reg        out_clear;
  reg  [4:0] alu;
  wire [3:0] ram_rdata;
  wire       exec;
  wire [7:0] op;
  wire [3:0] cst;
  wire [4:0] misc;

  // Five-bit sum with carry in, carry lands in bit four
  function [4:0] add5;
    input [3:0] a;
    input [3:0] b;
    input       cin;
    begin
      add5 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    end
  endfunction

  // ****************************************
  // Cycle framing
  // ****************************************
  assign exec       = i_ce & run_reg & (phase_reg == `LAST_PHASE);
  assign op         = i_rom_data;
  assign cst        = op[3:0];
  assign misc       = {op[5], op[3:0]};
  assign o_rom_addr = {page_reg, pc_reg};

  // Phase counter, instruction executes on the last of six phases
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      phase_reg   <= 3'h0;
      o_cycle_end <= 1'b0;
    end else if (i_ce) begin
      o_cycle_end <= exec;
      if (run_reg) begin
        phase_reg <= (phase_reg == `LAST_PHASE) ? 3'h0 : phase_reg + 3'h1;
      end
    end
  end

  // ****************************************
  // RAM
  // ****************************************
  nibble_ram nibble_ram_i (
    .i_clk   (i_clk),
    .i_we    (ram_we),
    .i_file  (file_reg),
    .i_word  (index_reg),
    .i_wdata (ram_wdata),
    .o_rdata (ram_rdata)
  );

  // ****************************************
  // Decode and execute
  // ****************************************
  // Next state of every register for the current instruction
  always @* begin
    acc_next    = acc_reg;
    index_next  = index_reg;
    file_next   = file_reg;
    latch_next  = latch_reg;
    status_next = 1'b1;
    pc_next     = pc_reg + 6'h01;
    page_next   = page_reg;
    pbuf_next   = pbuf_reg;
    ret_next    = ret_reg;
    ram_we      = 1'b0;
    ram_wdata   = acc_reg;
    strobe_we   = 1'b0;
    strobe_val  = 1'b0;
    out_load    = 1'b0;
    out_clear   = 1'b0;
    alu         = 5'h00;
    if (op[7:6] == `OP_BRANCH || op[7:6] == `OP_CALL) begin
      if (status_reg) begin
        pc_next   = op[5:0];
        page_next = pbuf_reg;
        if (op[7:6] == `OP_CALL) begin
          ret_next  = pc_reg + 6'h01;
          pbuf_next = page_reg;
        end
      end
    end else if (op[7:4] == `OP_LOAD_PAGE) begin
      pbuf_next = cst;
    end else if (op[7:4] == `OP_BITS) begin
      case (op[3:2])
        `BITS_SET: begin
          ram_we    = 1'b1;
          ram_wdata = ram_rdata | (`NIBBLE_ONE << op[1:0]);
        end
        `BITS_CLEAR: begin
          ram_we    = 1'b1;
          ram_wdata = ram_rdata & ~(`NIBBLE_ONE << op[1:0]);
        end
        `BITS_TEST: begin
          status_next = ram_rdata[op[1:0]];
        end
        default: begin
          file_next = op[1:0];
        end
      endcase
    end else if (op[7:4] == `OP_CONST_INDEX) begin
      index_next = cst;
    end else if (op[7:4] == `OP_CONST_RAM) begin
      ram_we     = 1'b1;
      ram_wdata  = cst;
      index_next = index_reg + `NIBBLE_ONE;
    end else if (op[7:4] == `OP_LE_CONST) begin
      alu         = add5(cst, ~acc_reg, 1'b1);
      status_next = alu[4];
    end else if (op[7:4] == `OP_NE_CONST) begin
      status_next = (index_reg != cst);
    end else begin
      case (misc)
        `M_MOVE_ACC_INDEX: index_next = acc_reg;
        `M_MOVE_INDEX_ACC: acc_next = index_reg;
        `M_ZERO_ACC:       acc_next = `NIBBLE_ZERO;
        `M_STORE_ACC:      ram_we = 1'b1;
        `M_STORE_BUMP: begin
          ram_we     = 1'b1;
          index_next = index_reg + `NIBBLE_ONE;
        end
        `M_STORE_ZERO: begin
          ram_we   = 1'b1;
          acc_next = `NIBBLE_ZERO;
        end
        `M_LOAD_INDEX_RAM: index_next = ram_rdata;
        `M_LOAD_ACC_RAM:   acc_next = ram_rdata;
        `M_SWAP_RAM_ACC: begin
          ram_we   = 1'b1;
          acc_next = ram_rdata;
        end
        `M_ADD_RAM_ACC: begin
          alu         = add5(ram_rdata, acc_reg, 1'b0);
          acc_next    = alu[3:0];
          status_next = alu[4];
        end
        `M_SUB_ACC_RAM: begin
          alu         = add5(ram_rdata, ~acc_reg, 1'b1);
          acc_next    = alu[3:0];
          status_next = alu[4];
        end
        `M_INC_RAM_ACC: begin
          alu         = add5(ram_rdata, `NIBBLE_ZERO, 1'b1);
          acc_next    = alu[3:0];
          status_next = alu[4];
        end
        `M_DEC_RAM_ACC: begin
          alu         = add5(ram_rdata, `NIBBLE_ALL, 1'b0);
          acc_next    = alu[3:0];
          status_next = alu[4];
        end
        `M_INC_ACC:  acc_next = acc_reg + `NIBBLE_ONE;
        `M_INC_INDEX: begin
          alu         = add5(index_reg, `NIBBLE_ZERO, 1'b1);
          index_next  = alu[3:0];
          status_next = alu[4];
        end
        `M_DEC_ACC: begin
          alu         = add5(acc_reg, `NIBBLE_ALL, 1'b0);
          acc_next    = alu[3:0];
          status_next = alu[4];
        end
        `M_DEC_INDEX: begin
          alu         = add5(index_reg, `NIBBLE_ALL, 1'b0);
          index_next  = alu[3:0];
          status_next = alu[4];
        end
        `M_ADD_SIX: begin
          alu         = add5(acc_reg, `K_SIX, 1'b0);
          acc_next    = alu[3:0];
          status_next = alu[4];
        end
        `M_ADD_EIGHT: begin
          alu         = add5(acc_reg, `K_EIGHT, 1'b0);
          acc_next    = alu[3:0];
          status_next = alu[4];
        end
        `M_ADD_TEN: begin
          alu         = add5(acc_reg, `K_TEN, 1'b0);
          acc_next    = alu[3:0];
          status_next = alu[4];
        end
        `M_NEGATE_ACC: begin
          alu         = add5(~acc_reg, `NIBBLE_ZERO, 1'b1);
          acc_next    = alu[3:0];
          status_next = alu[4];
        end
        `M_LE_RAM: begin
          alu         = add5(ram_rdata, ~acc_reg, 1'b1);
          status_next = alu[4];
        end
        `M_RAM_NONZERO:  status_next = (ram_rdata != `NIBBLE_ZERO);
        `M_INDEX_NE_ACC: begin
          status_next = (index_reg != acc_reg);
          latch_next  = (index_reg != acc_reg);
        end
        `M_KEYS_NONZERO: status_next = (i_keys != `NIBBLE_ZERO);
        `M_KEYS_TO_ACC:  acc_next = i_keys;
        `M_SET_STROBE: begin
          strobe_we  = 1'b1;
          strobe_val = 1'b1;
        end
        `M_CLEAR_STROBE: strobe_we = 1'b1;
        `M_OUTPUT_XFER:  out_load = 1'b1;
        `M_CLEAR_OUTPUT: out_clear = 1'b1;
        `M_INVERT_FILE:  file_next = ~file_reg;
        default: begin
          pc_next   = ret_reg;
          page_next = pbuf_reg;
        end
      endcase
    end
    if (!exec) begin
      ram_we = 1'b0;
    end
  end

  // ****************************************
  // Register update at the end of the cycle
  // ****************************************
  // All state commits together once per instruction cycle
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      acc_reg    <= `NIBBLE_ZERO;
      index_reg  <= `NIBBLE_ZERO;
      file_reg   <= 2'h0;
      status_reg <= `STATUS_RESET;
      latch_reg  <= 1'b0;
      pc_reg     <= 6'h00;
      page_reg   <= `NIBBLE_ZERO;
      pbuf_reg   <= `NIBBLE_ZERO;
      ret_reg    <= 6'h00;
      o_parallel <= 5'h00;
    end else if (exec) begin
      acc_reg    <= acc_next;
      index_reg  <= index_next;
      file_reg   <= file_next;
      status_reg <= status_next;
      latch_reg  <= latch_next;
      pc_reg     <= pc_next;
      page_reg   <= page_next;
      pbuf_reg   <= pbuf_next;
      ret_reg    <= ret_next;
      if (out_load) begin
        o_parallel <= {latch_reg, acc_reg};
      end else if (out_clear) begin
        o_parallel <= 5'h00;
      end
    end
  end

  // ****************************************
  // Strobe latches
  // ****************************************
  // One latch per index value below STROBES, only the addressed one changes
  genvar g;
  generate
    for (g = 0; g < STROBES; g = g + 1) begin : g_strobe
      always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
          o_strobe[g] <= 1'b0;
        end else if (exec && strobe_we && index_reg == g) begin
          o_strobe[g] <= strobe_val;
        end
      end
    end
  endgenerate

  // ****************************************
  // Register port
  // ****************************************
  // Control write and state readback, read data one cycle later
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      run_reg     <= `CTRL_RESET;
      o_reg_rdata <= 32'h00000000;
    end else if (i_ce) begin
      if (i_reg_wr && i_reg_addr == `REG_CTRL) begin
        run_reg <= i_reg_wdata[`CTRL_RUN_BIT];
      end
      if (i_reg_rd && i_reg_addr == `REG_CTRL) begin
        o_reg_rdata <= {31'h00000000, run_reg};
      end else if (i_reg_rd && i_reg_addr == `REG_STATE) begin
        o_reg_rdata <= {10'h000, page_reg, pc_reg, status_reg, latch_reg,
                        file_reg, index_reg, acc_reg};
      end else begin
        o_reg_rdata <= 32'h00000000;
      end
    end
  end

endmodule

// ==== tb/nibble_rom_model.sv ====
// Program memory model standing at the instruction fetch port
`timescale 1ns/10ps
module nibble_rom_model (
  input  wire logic [9:0] i_addr,
  output wire logic [7:0] o_data
);
  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] mem [0:1023];

  // Unused words hold a harmless page buffer load
  initial begin
    for (int k = 0; k < 1024; k++) begin
      mem[k] = 8'h10;
    end
  end

  // Combinational fetch, settled long before the execute phase
  assign o_data = mem[i_addr];
endmodule

// ==== tb/nibble_exec_asserts.sv ====
// Port level checker for the instruction execute core
`timescale 1ns/10ps
module nibble_exec_asserts #(
  parameter STROBES = 13
) (
  input wire               i_clk,
  input wire               i_resetn,
  input wire               i_ce,
  input wire [7:0]         i_rom_data,
  input wire [3:0]         i_keys,
  input wire [3:0]         i_reg_addr,
  input wire [31:0]        i_reg_wdata,
  input wire               i_reg_wr,
  input wire               i_reg_rd,
  input wire [9:0]         o_rom_addr,
  input wire [STROBES-1:0] o_strobe,
  input wire [4:0]         o_parallel,
  input wire               o_cycle_end,
  input wire [31:0]        o_reg_rdata
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  // ****************************************
  // Instruction cycle steps
  // ****************************************
  sequence exec_done;
    o_cycle_end && i_ce;
  endsequence
  sequence quiet_five;
    !o_cycle_end [*5];
  endsequence

  cycle_gap_a: assert property (exec_done |=> quiet_five)
    else $error("Instruction cycle shorter than six clocks");
  rom_hold_a: assert property ($changed(o_rom_addr) |-> o_cycle_end)
    else $error("Fetch address moved outside an execute edge");
  freeze_a: assert property (!i_ce |=> $stable(o_rom_addr) && $stable(o_strobe))
    else $error("State moved while clock enable was low");
  strobe_single_a: assert property ($changed(o_strobe) |->
    $onehot(o_strobe ^ $past(o_strobe))) else $error("More than one strobe latch changed");
  par_hold_a: assert property ($changed(o_parallel) |-> o_cycle_end)
    else $error("Parallel output moved outside an execute edge");
  par_clear_a: assert property (o_cycle_end && $past(i_rom_data) == 8'h2D |->
    o_parallel == 5'h00) else $error("Parallel output not cleared");
  jump_target_a: assert property (o_cycle_end && $past(i_rom_data[7]) |->
    o_rom_addr[5:0] == $past(i_rom_data[5:0]) || o_rom_addr[5:0] == $past(o_rom_addr[5:0])
    + 6'h01) else $error("Jump went neither to target nor to next word");
  rdata_idle_a: assert property (!i_reg_rd && i_ce |=> o_reg_rdata == 32'h0)
    else $error("Read data present without a read");
  unmapped_read_a: assert property (i_reg_rd && i_ce && i_reg_addr > 4'h1 |=>
    o_reg_rdata == 32'h0) else $error("Unmapped index returned data");
endmodule

bind nibble_cpu_instruction_execute nibble_exec_asserts #(.STROBES(STROBES)) nibble_exec_asserts_i (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_rom_data(i_rom_data), .i_keys(i_keys),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .o_rom_addr(o_rom_addr), .o_strobe(o_strobe),
  .o_parallel(o_parallel), .o_cycle_end(o_cycle_end), .o_reg_rdata(o_reg_rdata)
);

// ==== tb/nibble_cpu_instruction_execute_tb.sv ====
// Self-checking bench running a short program through the execute core
`timescale 1ns/10ps
`include "nibble_defs.vh"
module nibble_cpu_instruction_execute_tb;
  logic        i_clk, i_resetn, i_ce, i_reg_wr, i_reg_rd;
  logic [3:0]  i_keys, i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, got;
  logic [7:0]  i_rom_data;
  logic [9:0]  o_rom_addr, addr;
  logic [12:0] o_strobe;
  logic [4:0]  o_parallel;
  logic        o_cycle_end;
  logic [7:0]  ops [$];
  logic [31:0] exps [$];
  int          fails, total_checks, n;

  nibble_cpu_instruction_execute nibble_cpu_instruction_execute_i (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_ce(i_ce), .i_rom_data(i_rom_data),
    .i_keys(i_keys), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_rom_addr(o_rom_addr),
    .o_strobe(o_strobe), .o_parallel(o_parallel), .o_cycle_end(o_cycle_end),
    .o_reg_rdata(o_reg_rdata)
  );
  nibble_rom_model nibble_rom_model_i (.i_addr(o_rom_addr), .o_data(i_rom_data));

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial begin
    #20000;
    fails++;
    conclude();
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      fails++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_wr <= 1'b1; i_reg_addr <= a; i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_reg_rd <= 1'b1; i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask
  // Program word with the state expected once it has executed
  task automatic r(input logic [7:0] op, input logic [3:0] pg, input logic [5:0] pc,
                   input logic s, input logic l, input logic [1:0] x,
                   input logic [3:0] y, input logic [3:0] a);
    ops.push_back(op);
    exps.push_back({10'h000, pg, pc, s, l, x, y, a});
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    i_resetn = 1'b0; i_ce = 1'b1; i_keys = 4'h9; i_reg_addr = 4'h0;
    i_reg_wdata = 32'h0; i_reg_wr = 1'b0; i_reg_rd = 1'b0;
    r(8'h45,0,1,1,0,0,5,0); r(8'h01,0,2,1,0,0,5,5);
    r(8'h22,0,3,0,0,0,5,13); r(8'h21,0,4,1,0,0,5,3);
    r(8'h23,0,5,0,0,0,5,13); r(8'h03,0,6,1,0,0,5,13);
    r(8'h02,0,7,1,0,0,5,0); r(8'h07,0,8,1,0,0,5,13);
    r(8'h09,0,9,1,0,0,5,10); r(8'h0A,0,10,1,0,0,5,3);
    r(8'h0F,0,11,1,0,0,5,2); r(8'h24,0,12,0,0,0,5,14);
    r(8'h27,0,13,1,1,0,5,14); r(8'h2C,0,14,1,1,0,5,14);
    r(8'h2A,0,15,1,1,0,5,14); r(8'h20,0,16,1,1,0,4,14);
    r(8'h94,0,20,1,1,0,4,14); r(8'h40,0,21,1,1,0,0,14);
    r(8'h20,0,22,0,1,0,15,14); r(8'hA8,0,23,1,1,0,15,14);
    r(8'h12,0,24,1,1,0,15,14); r(8'hCA,2,10,1,1,0,15,14);
    r(8'h29,2,11,1,1,0,15,9); r(8'h2F,0,25,1,1,0,15,9);
    r(8'h0E,0,26,1,1,0,0,9); r(8'h0D,0,27,1,1,0,0,10);
    r(8'h59,0,28,0,1,0,0,10); r(8'h3F,0,29,1,1,3,0,10);
    r(8'h2E,0,30,1,1,0,0,10); r(8'h64,0,31,1,1,0,1,10);
    r(8'h20,0,32,1,1,0,0,10); r(8'h30,0,33,1,1,0,0,10);
    r(8'h38,0,34,1,1,0,0,10); r(8'h36,0,35,1,1,0,0,10);
    r(8'h3A,0,36,0,1,0,0,10); r(8'h07,0,37,1,1,0,0,1);
    r(8'h26,0,38,1,1,0,0,1); r(8'h70,0,39,0,1,0,0,1);
    r(8'h25,0,40,1,1,0,0,1); r(8'h0C,0,41,1,1,0,0,0);
    r(8'h0B,0,42,0,1,0,0,2); r(8'h08,0,43,1,1,0,0,1);
    r(8'h06,0,44,1,1,0,2,1); r(8'h05,0,45,1,1,0,2,0);
    r(8'h04,0,46,1,1,0,3,0); r(8'h00,0,47,1,1,0,0,0);
    r(8'h28,0,48,1,1,0,0,0); r(8'h2D,0,49,1,1,0,0,0);
    r(8'h45,0,50,1,1,0,5,0); r(8'h2B,0,51,1,1,0,5,0);
    r(8'h24,0,52,1,1,0,5,0); r(8'h40,0,53,1,1,0,0,0);
    r(8'h27,0,54,0,0,0,0,0); r(8'h4D,0,55,1,0,0,13,0);
    r(8'h2A,0,56,1,0,0,13,0); r(8'h4C,0,57,1,0,0,12,0);
    r(8'h2A,0,58,1,0,0,12,0);
    // Program loaded after the model has filled its defaults
    repeat (6) @(posedge i_clk);
    addr = 10'h000;
    foreach (ops[i]) begin
      nibble_rom_model_i.mem[addr] = ops[i];
      addr = exps[i][21:12];
    end
    i_resetn <= 1'b1;
    rd(`REG_CTRL, got);
    check(got, 32'h1);
    rd(`REG_STATE, got);
    check(got, 32'h800);
    foreach (ops[i]) begin
      n = 0;
      do begin
        @(posedge i_clk);
        #1 n++;
      end while (o_cycle_end !== 1'b1 && n < 20);
      if (i > 0) check(n, 4);
      rd(`REG_STATE, got);
      check(got, exps[i]);
      check(o_parallel, (i >= 13 && i < 47) ? 5'h1E : 5'h00);
      check(o_strobe, (i >= 14 && i < 49) ? 13'h0020 : (i == 56) ? 13'h1000 : 13'h0000);
    end
    check(o_strobe, 13'h1000);
    rd(4'h7, got);
    check(got, 32'h0);
    wr(`REG_CTRL, 32'h0);
    #1 addr = o_rom_addr;
    repeat (15) @(posedge i_clk);
    check(o_rom_addr, addr);
    wr(`REG_CTRL, 32'h1);
    i_ce <= 1'b0;
    #1 addr = o_rom_addr;
    repeat (15) @(posedge i_clk);
    check(o_rom_addr, addr);
    i_ce <= 1'b1;
    repeat (15) @(posedge i_clk);
    // Reset in mid-run brings the state back to its start values
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    rd(`REG_STATE, got);
    check(got, 32'h800);
    check(o_strobe, 13'h0000);
    check(o_parallel, 5'h00);
    conclude();
  end
endmodule
